// file: crcu_engine.sv
// What this block does
// - CRC is 16 bits with fixed generator polynomial 0x1021.
// - Each input byte is XORed into the top eight result bits first.
// - Eight steps: shift left, XOR polynomial when old top bit set.
// - Preset select: 0 gives 0x0000, 1 gives 0xFFFF.
// - Writing 1 to init strobe loads the selected preset.
// - Every input byte write made with clock enable high outside an auto run folds into the result immediately.
// - With auto enable set and a nonzero block count, any control write starts the auto run.
// - CPU stalls during the auto run and resumes when it ends.
// - Byte pointer picks result byte for window access, advances after each.
// - Result holds until re-initialised, overwritten or fed new bytes.
`timescale 1ns/1ps
`default_nettype none

module crcu_engine
    import crcu_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire crcu_bus_type bus,
    output logic [7:0]        rdata,
    output logic              cpu_stall,
    output logic [15:0]       flash_addr,
    output logic              flash_rd,
    input  wire logic [7:0]   flash_data
);

    crcu_regs_type r;
    crcu_regs_type next_r;

    logic wr_ctrl;
    logic wr_in;
    logic wr_win;
    logic rd_win;

    always_comb begin
        wr_ctrl = bus.wr && (bus.addr == CRCU_ADDR_CTRL);
        wr_in   = bus.wr && (bus.addr == CRCU_ADDR_INPUT);
        wr_win  = bus.wr && (bus.addr == CRCU_ADDR_WINDOW);
        rd_win  = bus.rd && (bus.addr == CRCU_ADDR_WINDOW);
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_r          = r;
        next_r.flash_rd = 1'b0;
        // Register writes are ignored while stalled; the CPU cannot issue them anyway
        if (r.state == CRCU_IDLE) begin
            if (wr_ctrl) begin
                next_r.ptr     = bus.wdata[CRCU_CTRL_PTR_BIT];
                next_r.val_sel = bus.wdata[CRCU_CTRL_VAL_BIT];
                if (bus.wdata[CRCU_CTRL_INIT_BIT]) begin
                    next_r.result = bus.wdata[CRCU_CTRL_VAL_BIT] ? CRCU_PRESET_ONES
                                                                 : CRCU_PRESET_ZERO;
                end
                if (r.auto_en && (r.count != 8'h00)) begin
                    next_r.state      = CRCU_FETCH;
                    next_r.stall      = 1'b1;
                    next_r.byte_idx   = 8'h00;
                    next_r.flash_addr = {1'b0, r.page, 8'h00};
                    next_r.flash_rd   = 1'b1;
                end
            end
            if (wr_in) begin
                next_r.last_in = bus.wdata;
                next_r.result  = crcu_fold(r.result, bus.wdata);
            end
            if (wr_win) begin
                if (r.ptr) begin
                    next_r.result[15:8] = bus.wdata;
                end else begin
                    next_r.result[7:0] = bus.wdata;
                end
            end
            if (wr_win || rd_win) begin
                next_r.ptr = ~r.ptr;
            end
            if (bus.wr && (bus.addr == CRCU_ADDR_AUTO)) begin
                next_r.auto_en = bus.wdata[CRCU_AUTO_EN_BIT];
                next_r.page    = bus.wdata[6:0];
            end
            if (bus.wr && (bus.addr == CRCU_ADDR_COUNT)) begin
                next_r.count = bus.wdata;
            end
            if (bus.wr && (bus.addr == CRCU_ADDR_FLIP)) begin
                next_r.flip = {<<{bus.wdata}};
            end
            if (bus.rd) begin
                case (bus.addr)
                    CRCU_ADDR_CTRL:   next_r.rdata = {4'h0, 1'b0, r.val_sel, 1'b0, r.ptr};
                    CRCU_ADDR_INPUT:  next_r.rdata = r.last_in;
                    CRCU_ADDR_WINDOW: next_r.rdata = r.ptr ? r.result[15:8] : r.result[7:0];
                    CRCU_ADDR_AUTO:   next_r.rdata = {r.auto_en, r.page};
                    CRCU_ADDR_COUNT:  next_r.rdata = r.count;
                    CRCU_ADDR_FLIP:   next_r.rdata = r.flip;
                    default:          next_r.rdata = 8'h00;
                endcase
            end
        end
        case (r.state)
            CRCU_IDLE: begin
            end
            CRCU_FETCH: begin
                // Flash answers one cycle after the read strobe
                next_r.state = CRCU_FOLD;
            end
            CRCU_FOLD: begin
                next_r.result = crcu_fold(r.result, flash_data);
                if (r.byte_idx == 8'(CRCU_BLOCK_BYTES - 1)) begin
                    next_r.count = r.count - 8'h01;
                    next_r.page  = r.page + 7'h01;
                end
                if ((r.byte_idx == 8'(CRCU_BLOCK_BYTES - 1)) && (r.count == 8'h01)) begin
                    next_r.state = CRCU_IDLE;
                    next_r.stall = 1'b0;
                end else begin
                    next_r.state      = CRCU_FETCH;
                    next_r.byte_idx   = r.byte_idx + 8'h01;
                    next_r.flash_addr = r.flash_addr + 16'h0001;
                    next_r.flash_rd   = 1'b1;
                end
            end
            default: begin
                next_r.state = CRCU_IDLE;
                next_r.stall = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{state: CRCU_IDLE, result: CRCU_RESULT_RESET, ptr: 1'b0, val_sel: 1'b0,
                   auto_en: 1'b0, page: 7'h00, count: CRCU_BYTE_RESET, byte_idx: 8'h00,
                   last_in: CRCU_BYTE_RESET, flip: CRCU_BYTE_RESET, rdata: CRCU_BYTE_RESET,
                   stall: 1'b0, flash_addr: 16'h0000, flash_rd: 1'b0};
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    always_comb begin
        rdata      = r.rdata;
        cpu_stall  = r.stall;
        flash_addr = r.flash_addr;
        flash_rd   = r.flash_rd;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_init_ones;
        clk_en && r.state == CRCU_IDLE && wr_ctrl && bus.wdata[CRCU_CTRL_INIT_BIT]
            && bus.wdata[CRCU_CTRL_VAL_BIT] && !wr_in && !wr_win;
    endsequence

    sequence s_init_zero;
        clk_en && r.state == CRCU_IDLE && wr_ctrl && bus.wdata[CRCU_CTRL_INIT_BIT]
            && !bus.wdata[CRCU_CTRL_VAL_BIT] && !wr_in && !wr_win;
    endsequence

    chk_init_ones_preset: assert property (s_init_ones |=> r.result == 16'hFFFF)
        else $error("Init with select 1 did not give all ones");

    chk_init_zero_preset: assert property (s_init_zero |=> r.result == 16'h0000)
        else $error("Init with select 0 did not give zero");

    chk_ctrl_select: assert property (clk_en && r.state == CRCU_IDLE && wr_ctrl
            |=> r.val_sel == $past(bus.wdata[CRCU_CTRL_VAL_BIT]))
        else $error("Control write did not load the preset select");

    // ************************************************************
    // Byte fold and hold checks
    // ************************************************************
    chk_fold_zero_byte: assert property (clk_en && r.state == CRCU_IDLE && wr_in && !wr_ctrl
            && r.result == 16'hFFFF && bus.wdata == 8'h00 |=> r.result == 16'hE1F0)
        else $error("Byte fold gave wrong CRC");

    chk_fold_one_byte: assert property (clk_en && r.state == CRCU_IDLE && wr_in && !wr_ctrl
            && r.result == 16'h0000 && bus.wdata == 8'h01 |=> r.result == 16'h1021)
        else $error("Byte fold of 0x01 gave wrong CRC");

    chk_input_keep: assert property (clk_en && r.state == CRCU_IDLE && wr_in
            |=> r.last_in == $past(bus.wdata))
        else $error("Input register lost the written byte");

    chk_result_hold: assert property (r.state == CRCU_IDLE
            && !(clk_en && (wr_in || wr_win || wr_ctrl)) |=> $stable(r.result))
        else $error("Result changed with no cause");

    // Catches a fold or load that slips past a frozen clock
    chk_freeze_result: assert property (!clk_en |=> $stable(r.result))
        else $error("Result moved while the clock enable was low");

    // ************************************************************
    // Result window and bit reverse checks
    // ************************************************************
    chk_ptr_advance: assert property (clk_en && r.state == CRCU_IDLE && (rd_win || wr_win) && !wr_ctrl
            |=> r.ptr != $past(r.ptr))
        else $error("Result pointer did not advance");

    chk_ptr_from_ctrl: assert property (clk_en && r.state == CRCU_IDLE && wr_ctrl
            |=> r.ptr == $past(bus.wdata[CRCU_CTRL_PTR_BIT]))
        else $error("Control write did not load the pointer");

    chk_window_read: assert property (clk_en && r.state == CRCU_IDLE && rd_win && r.ptr
            |=> rdata == $past(r.result[15:8]))
        else $error("Window read returned wrong byte");

    chk_window_read_low: assert property (clk_en && r.state == CRCU_IDLE && rd_win && !r.ptr
            |=> rdata == $past(r.result[7:0]))
        else $error("Window read of the low byte was wrong");

    chk_window_write_low: assert property (clk_en && r.state == CRCU_IDLE && wr_win && !r.ptr
            |=> r.result[7:0] == $past(bus.wdata))
        else $error("Window write missed the low byte");

    chk_window_write_high: assert property (clk_en && r.state == CRCU_IDLE && wr_win && r.ptr
            |=> r.result[15:8] == $past(bus.wdata))
        else $error("Window write missed the high byte");

    // Software may read late; the last answer must not drift before the next read of any address
    chk_rdata_hold: assert property (!(clk_en && r.state == CRCU_IDLE && bus.rd) |=> $stable(rdata))
        else $error("Read data changed without a read");

    chk_flip_write: assert property (clk_en && r.state == CRCU_IDLE && bus.wr && bus.addr == CRCU_ADDR_FLIP
            |=> r.flip[7] == $past(bus.wdata[0]) && r.flip[0] == $past(bus.wdata[7]))
        else $error("Bit reverse register stored wrong order");

    chk_flip_read: assert property (clk_en && r.state == CRCU_IDLE && bus.wr && bus.addr == CRCU_ADDR_FLIP
            ##1 !(bus.wr && bus.addr == CRCU_ADDR_FLIP)
            ##1 clk_en && r.state == CRCU_IDLE && bus.rd && bus.addr == CRCU_ADDR_FLIP && !bus.wr
            |=> rdata[0] == $past(bus.wdata[7], 3) && rdata[7] == $past(bus.wdata[0], 3))
        else $error("Bit reverse read wrong");

    // ************************************************************
    // Automatic run checks
    // ************************************************************
    sequence s_auto_go;
        clk_en && r.state == CRCU_IDLE && wr_ctrl && r.auto_en && r.count != 8'h00;
    endsequence

    sequence s_last_fold;
        clk_en && r.state == CRCU_FOLD && r.byte_idx == 8'(CRCU_BLOCK_BYTES - 1) && r.count == 8'h01;
    endsequence

    chk_auto_start: assert property (s_auto_go |=> cpu_stall && flash_rd)
        else $error("Auto run did not start");

    chk_auto_first_addr: assert property (s_auto_go |=> flash_addr == {1'b0, $past(r.page), 8'h00})
        else $error("Auto run began at the wrong page");

    chk_auto_refused: assert property (clk_en && r.state == CRCU_IDLE && wr_ctrl
            && (!r.auto_en || r.count == 8'h00) |=> !cpu_stall && !flash_rd)
        else $error("Auto run started without enable or blocks");

    chk_idle_no_flash: assert property (r.state == CRCU_IDLE && !(clk_en && wr_ctrl) |=> !flash_rd)
        else $error("Flash read outside an auto run");

    chk_fetch_read: assert property (r.state == CRCU_FETCH |-> flash_rd)
        else $error("Flash read missing in fetch state");

    // One strobe per byte keeps the flash at a read every second cycle
    chk_flash_gap: assert property (clk_en && flash_rd |=> !flash_rd)
        else $error("Flash read strobe longer than one cycle");

    chk_addr_step: assert property (clk_en && r.state == CRCU_FOLD ##1 flash_rd
            |-> flash_addr == $past(flash_addr) + 16'h0001)
        else $error("Flash address did not step by one");

    chk_block_count: assert property (clk_en && r.state == CRCU_FOLD
            && r.byte_idx == 8'(CRCU_BLOCK_BYTES - 1) |=> r.count == $past(r.count) - 8'h01)
        else $error("Block count did not step down after a block");

    chk_page_step: assert property (clk_en && r.state == CRCU_FOLD
            && r.byte_idx == 8'(CRCU_BLOCK_BYTES - 1) |=> r.page == $past(r.page) + 7'h01)
        else $error("Page did not step after a block");

    // Bus writes that arrive during a run are dropped
    chk_busy_hold: assert property (clk_en && r.state == CRCU_FETCH |=> $stable(r.result))
        else $error("Result moved while waiting for flash");

    chk_busy_ptr: assert property (r.state != CRCU_IDLE |=> $stable(r.ptr))
        else $error("Pointer moved during an auto run");

    chk_stall_end: assert property (s_last_fold |=> !cpu_stall && r.state == CRCU_IDLE)
        else $error("Stall did not drop after the last block");

    chk_stall_match: assert property (cpu_stall == (r.state != CRCU_IDLE))
        else $error("Stall does not match busy state");

endmodule : crcu_engine

`default_nettype wire

// file: crcu_pkg.sv
package crcu_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0]  CRCU_ADDR_CTRL    = 8'h84;
    localparam logic [7:0]  CRCU_ADDR_INPUT   = 8'h85;
    localparam logic [7:0]  CRCU_ADDR_WINDOW  = 8'h86;
    localparam logic [7:0]  CRCU_ADDR_AUTO    = 8'h87;
    localparam logic [7:0]  CRCU_ADDR_COUNT   = 8'h88;
    localparam logic [7:0]  CRCU_ADDR_FLIP    = 8'h89;

    // ************************************************************
    // Control and auto register fields
    // ************************************************************
    localparam int          CRCU_CTRL_PTR_BIT   = 0;
    localparam int          CRCU_CTRL_VAL_BIT   = 2;
    localparam int          CRCU_CTRL_INIT_BIT  = 3;
    localparam int          CRCU_AUTO_EN_BIT    = 7;

    // ************************************************************
    // Algorithm constants and reset values
    // ************************************************************
    localparam logic [15:0] CRCU_POLY          = 16'h1021;
    localparam logic [15:0] CRCU_PRESET_ZERO   = 16'h0000;
    localparam logic [15:0] CRCU_PRESET_ONES   = 16'hFFFF;
    localparam logic [7:0]  CRCU_BYTE_RESET    = 8'h00;
    localparam logic [15:0] CRCU_RESULT_RESET  = 16'h0000;
    localparam int          CRCU_BLOCK_BYTES   = 256;

    typedef enum logic [1:0] {
        CRCU_IDLE  = 2'b00,
        CRCU_FETCH = 2'b01,
        CRCU_FOLD  = 2'b10
    } crcu_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crcu_bus_type;

    typedef struct packed {
        crcu_state_type state;
        logic [15:0]    result;
        logic           ptr;
        logic           val_sel;
        logic           auto_en;
        logic [6:0]     page;
        logic [7:0]     count;
        logic [7:0]     byte_idx;
        logic [7:0]     last_in;
        logic [7:0]     flip;
        logic [7:0]     rdata;
        logic           stall;
        logic [15:0]    flash_addr;
        logic           flash_rd;
    } crcu_regs_type;

    // Fold one byte into a CRC value, MSB first
    function automatic logic [15:0] crcu_fold(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (c[15]) begin
                c = {c[14:0], 1'b0} ^ CRCU_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crcu_fold

endpackage : crcu_pkg

// file: crcu_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Flash array: answers the cycle after each read strobe
// ************************************************************
module crcu_flash_model (
    input  wire logic        sys_clk,
    input  wire logic        flash_rd,
    input  wire logic [15:0] flash_addr,
    output var  logic [7:0]  flash_data
);
    initial flash_data = 8'h00;
    // Off its valid cycle the data toggles, so a late sample cannot match
    always @(posedge sys_clk) begin
        if (flash_rd) begin
            flash_data <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5A;
        end else begin
            flash_data <= ~flash_data;
        end
    end
endmodule : crcu_flash_model
`default_nettype wire

// file: tb_crc16_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_crc16_byte_engine;
    import crcu_pkg::*;
    logic         sys_clk    = 1'b0;
    logic         rst_n      = 1'b0;
    logic         clk_en     = 1'b1;
    crcu_bus_type bus        = '0;
    logic [7:0]   rdata;
    logic         cpu_stall;
    logic [15:0]  flash_addr;
    logic         flash_rd;
    logic [7:0]   flash_data;
    logic [7:0]   exp_q[$];
    logic         rd_d       = 1'b0;
    logic [31:0]  seed       = 32'h617e_8009;
    logic [15:0]  crc;
    logic [7:0]   b;
    int           err_count  = 0;
    int           num_checks = 0;
    int           n;

    always #50 sys_clk = ~sys_clk;

    crcu_engine DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata),
        .cpu_stall(cpu_stall), .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_data(flash_data));
    crcu_flash_model FLASH (.sys_clk(sys_clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
        .flash_data(flash_data));

    function automatic logic [15:0] ref_fold(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : ref_fold

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expd);
        num_checks++;
        if (seen !== expd) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, expd, seen);
        end
    endtask : check

    task automatic give_verdict;
        check("leftover reads", 16'(exp_q.size()), 16'h0000);
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // One idle cycle between accesses keeps each strobe a clean pulse
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        bus = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        #1;
        bus = '0;
    endtask : access

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        access(1'b0, a, 8'h00);
    endtask : rd

    always @(posedge sys_clk) rd_d <= bus.rd && !cpu_stall && clk_en;
    always @(negedge sys_clk) begin
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 16'h0001, 16'h0000);
            end else begin
                check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
            end
        end
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        rd(CRCU_ADDR_INPUT, 8'h00);
        rd(CRCU_ADDR_WINDOW, 8'h00);
        rd(8'h80, 8'h00);
        for (int v = 0; v < 2; v++) begin
            crc = v ? 16'hFFFF : 16'h0000;
            access(1'b1, CRCU_ADDR_CTRL, v ? 8'h0C : 8'h08);
            rd(CRCU_ADDR_WINDOW, crc[7:0]);
            rd(CRCU_ADDR_WINDOW, crc[15:8]);
            // Known single-byte results from each preset
            access(1'b1, CRCU_ADDR_INPUT, v ? 8'h00 : 8'h01);
            crc = v ? 16'hE1F0 : 16'h1021;
            rd(CRCU_ADDR_WINDOW, crc[7:0]);
            rd(CRCU_ADDR_WINDOW, crc[15:8]);
        end
        for (int k = 0; k < 20; k++) begin
            seed = lfsr(seed);
            access(1'b1, CRCU_ADDR_INPUT, seed[7:0]);
            crc = ref_fold(crc, seed[7:0]);
        end
        rd(CRCU_ADDR_WINDOW, crc[7:0]);
        rd(CRCU_ADDR_WINDOW, crc[15:8]);
        rd(CRCU_ADDR_WINDOW, crc[7:0]);
        rd(CRCU_ADDR_INPUT, seed[7:0]);
        access(1'b1, CRCU_ADDR_CTRL, 8'h00);
        access(1'b1, CRCU_ADDR_WINDOW, 8'h34);
        access(1'b1, CRCU_ADDR_WINDOW, 8'h12);
        // A byte offered while the clock is frozen must be lost
        clk_en = 1'b0;
        access(1'b1, CRCU_ADDR_INPUT, 8'hA5);
        clk_en = 1'b1;
        rd(CRCU_ADDR_WINDOW, 8'h34);
        rd(CRCU_ADDR_WINDOW, 8'h12);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            for (int i = 0; i < 8; i++) b[i] = seed[7 - i];
            access(1'b1, CRCU_ADDR_FLIP, seed[7:0]);
            rd(CRCU_ADDR_FLIP, b);
        end
        access(1'b1, CRCU_ADDR_CTRL, 8'h0C);
        access(1'b1, CRCU_ADDR_AUTO, 8'h85);
        access(1'b1, CRCU_ADDR_COUNT, 8'h02);
        crc = 16'hFFFF;
        for (int a = 16'h0500; a < 16'h0700; a++) crc = ref_fold(crc, a[7:0] ^ a[15:8] ^ 8'h5A);
        access(1'b1, CRCU_ADDR_CTRL, 8'h04);
        check("stall start", {15'h0000, cpu_stall}, 16'h0001);
        access(1'b1, CRCU_ADDR_INPUT, 8'h77);
        n = 2;
        while (cpu_stall && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 2000) begin
            check("stall timeout", 16'h0001, 16'h0000);
        end else begin
            check("stall cycles", n[15:0], 16'h0400);
            access(1'b1, CRCU_ADDR_AUTO, 8'h00);
            rd(CRCU_ADDR_COUNT, 8'h00);
            rd(CRCU_ADDR_WINDOW, crc[7:0]);
            rd(CRCU_ADDR_WINDOW, crc[15:8]);
            // A zero block count must leave the engine idle
            access(1'b1, CRCU_ADDR_AUTO, 8'h80);
            access(1'b1, CRCU_ADDR_CTRL, 8'h00);
            check("idle stall", {15'h0000, cpu_stall}, 16'h0000);
        end
        repeat (2) @(posedge sys_clk);
        give_verdict();
    end
endmodule : tb_crc16_byte_engine
`default_nettype wire
